// File: buck_boost_pkg.sv
// Package: register map, field layout, reset values and timing constants
package buck_boost_pkg;

  // ----------------------------------------
  // Register map (byte address is 4 x index)
  // ----------------------------------------
  localparam logic [7:0] CFG_INDEX = 8'h19;
  localparam logic [7:0] KEY_INDEX = 8'h30;
  localparam logic [7:0] STAT_INDEX = 8'h31;
  localparam logic [7:0] ADDR_W = 8'h08;

  // ----------------------------------------
  // Configuration field layout and values
  // ----------------------------------------
  localparam int SKIP_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam logic [7:0] CFG_RESET = 8'h94;
  localparam logic [7:0] CFG_STRAP_DEFAULT = 8'h94;
  localparam logic [5:0] CODE_FIRST_RSVD = 6'h35;
  localparam logic [5:0] CODE_COARSE = 6'h10;
  localparam logic [7:0] UNLOCK_KEY = 8'h7D;

  // ----------------------------------------
  // Status field layout
  // ----------------------------------------
  localparam int ST_BLANK = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_UNLOCKED = 2;
  localparam int ST_STRAP = 3;
  localparam int ST_RSVD_CODE = 4;

  // ----------------------------------------
  // Setpoint scale in millivolts
  // ----------------------------------------
  localparam int MV_FINE_BASE = 1175;
  localparam int MV_FINE_STEP = 25;
  localparam int MV_COARSE_BASE = 1600;
  localparam int MV_COARSE_STEP = 50;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int BLANK_MS = 5;
  localparam int BLANK_CYCLES = (CLK_HZ / 1000) * BLANK_MS;

  typedef struct packed {
    logic pulse_skip_enable;
    logic reserved;
    logic [5:0] code;
  } cfg_t;

  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    int mv;
    mv = 0;
    if (code < CODE_COARSE) begin
      mv = MV_FINE_BASE + MV_FINE_STEP * int'(code);
    end else if (code < CODE_FIRST_RSVD) begin
      mv = MV_COARSE_BASE + MV_COARSE_STEP * int'(code - CODE_COARSE);
    end
    return mv[11:0];
  endfunction

endpackage

// File: buck_boost_setpoint_reg.sv
// Buck-boost converter setpoint register with Avalon-MM access
//
// Function
// - The setpoint register sits at index 0x19 and resets to 0x94.
// - A setpoint write only lands after a valid unlock, else it is dropped.
// - Every accepted setpoint write masks over/under-voltage faults for 5 ms.
// - Bit 7 enables pulse skipping, resets to 1, 0 forces fixed frequency.
// - Bits 5..0 set the output voltage from 1.175 V to 3.400 V.
// - A strap input sampled at power-up may pick another start value.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module buck_boost_setpoint_reg #(
  parameter int BLANK_CYCLES = buck_boost_pkg::BLANK_CYCLES,
  parameter logic [7:0] STRAP_VALUE = buck_boost_pkg::CFG_STRAP_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic strap_default_select,
  input wire logic ov_fault_raw,
  input wire logic uv_fault_raw,
  output logic ov_fault,
  output logic uv_fault,
  output logic supervision_blank,
  output buck_boost_pkg::cfg_t cfg,
  output logic [11:0] setpoint_mv,
  output logic code_reserved
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'(buck_boost_pkg::CFG_INDEX << 2);
  localparam logic [7:0] KEY_ADDR = 8'(buck_boost_pkg::KEY_INDEX << 2);
  localparam logic [7:0] STAT_ADDR = 8'(buck_boost_pkg::STAT_INDEX << 2);

  wire hit_cfg = (avs_address == CFG_ADDR);
  wire hit_key = (avs_address == KEY_ADDR);
  wire hit_stat = (avs_address == STAT_ADDR);

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state: the request is seen, then accepted on the next edge.
  // Costs a cycle per access but lets read data come from a flip-flop.
  logic ack;
  wire req = avs_read | avs_write;
  wire accept = req & ack;
  wire lane0 = avs_byteenable[0];
  wire wr_acc = avs_write & accept & lane0;

  assign avs_waitrequest = req & ~ack;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ----------------------------------------
  // Write qualification
  // ----------------------------------------
  logic unlocked;
  wire cfg_wr = wr_acc & hit_cfg;
  wire key_wr = wr_acc & hit_key;
  wire stat_wr = wr_acc & hit_stat;
  wire cfg_take = cfg_wr & unlocked;
  wire cfg_refuse = cfg_wr & ~unlocked;
  wire any_other_wr = wr_acc & ~hit_key;

  write_unlock_gate #(
    .KEY(buck_boost_pkg::UNLOCK_KEY)
  ) u_unlock (
    .mclk(mclk),
    .rst_n(rst_n),
    .key_write(key_wr),
    .key_data(avs_writedata[7:0]),
    .other_write(any_other_wr),
    .unlocked(unlocked)
  );

  // ----------------------------------------
  // Setpoint register
  // ----------------------------------------
  logic strap_done;
  logic strap_used;
  buck_boost_pkg::cfg_t next_cfg;
  buck_boost_pkg::cfg_t wr_cfg;
  buck_boost_pkg::cfg_t strap_cfg;

  assign wr_cfg.pulse_skip_enable =
    avs_writedata[buck_boost_pkg::SKIP_BIT];
  assign wr_cfg.reserved = 1'b0;
  assign wr_cfg.code = avs_writedata[buck_boost_pkg::CODE_MSB:0];

  assign strap_cfg.pulse_skip_enable =
    STRAP_VALUE[buck_boost_pkg::SKIP_BIT];
  assign strap_cfg.reserved = 1'b0;
  assign strap_cfg.code = STRAP_VALUE[buck_boost_pkg::CODE_MSB:0];

  assign next_cfg = !strap_done ?
                    (strap_default_select ? strap_cfg : cfg) :
                    cfg_take ? wr_cfg : cfg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= buck_boost_pkg::cfg_t'(buck_boost_pkg::CFG_RESET);
    end else begin
      cfg <= next_cfg;
    end
  end

  // Strap is caught once, on the first edge after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      strap_used <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_used <= strap_default_select;
    end
  end

  // ----------------------------------------
  // Supervision blanking
  // ----------------------------------------
  // write starts blanking
  supervision_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(cfg_take),
    .active(supervision_blank)
  );

  assign ov_fault = ov_fault_raw & ~supervision_blank;
  assign uv_fault = uv_fault_raw & ~supervision_blank;

  // ----------------------------------------
  // Derived setpoint
  // ----------------------------------------
  // Reserved codes report 0 mV; the register still stores them as written
  wire rsvd_now = (cfg.code >= buck_boost_pkg::CODE_FIRST_RSVD);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_mv <= 12'h000;
      code_reserved <= 1'b0;
    end else begin
      setpoint_mv <= buck_boost_pkg::code_to_mv(cfg.code);
      code_reserved <= rsvd_now;
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  // Refused flag: a new refusal wins over a same-cycle clear
  logic refused;
  wire clr_refused = stat_wr & avs_writedata[buck_boost_pkg::ST_REFUSED];
  wire next_refused = cfg_refuse | (refused & ~clr_refused);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refused <= 1'b0;
    end else begin
      refused <= next_refused;
    end
  end

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[buck_boost_pkg::ST_BLANK] = supervision_blank;
    status[buck_boost_pkg::ST_REFUSED] = refused;
    status[buck_boost_pkg::ST_UNLOCKED] = unlocked;
    status[buck_boost_pkg::ST_STRAP] = strap_used;
    status[buck_boost_pkg::ST_RSVD_CODE] = code_reserved;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped and key addresses read as zero
  wire [7:0] rd_byte = hit_cfg ? cfg :
                       hit_stat ? status : 8'h00;

  // Captured in the wait cycle, stable at the accepting edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

endmodule

// File: setpoint_monitor.sv
// Port checker for the converter setpoint register
`timescale 1ns/1ps
module setpoint_monitor #(
  parameter int BLANK_CYCLES = buck_boost_pkg::BLANK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ov_fault_raw,
  input wire logic uv_fault_raw,
  input wire logic ov_fault,
  input wire logic uv_fault,
  input wire logic supervision_blank,
  input wire buck_boost_pkg::cfg_t cfg,
  input wire logic [11:0] setpoint_mv,
  input wire logic code_reserved
);
  int blank_len;
  logic [11:0] exp_mv;
  wire logic take = avs_write && !avs_waitrequest && avs_address == 8'h64;
  assign exp_mv = cfg.code < 6'h10 ? 12'h497 + 12'h019 * cfg.code :
    cfg.code < 6'h35 ? 12'h640 + 12'h032 * (cfg.code - 6'h10) : 12'h000;
  // Length of the current masking run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blank_len <= 0;
    end else begin
      blank_len <= supervision_blank ? blank_len + 1 : 0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_wait_cycle: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
  a_ov_masked: assert property (ov_fault ==
    (ov_fault_raw && !supervision_blank)) else $error("ov mask wrong");
  a_uv_masked: assert property (uv_fault ==
    (uv_fault_raw && !supervision_blank)) else $error("uv mask wrong");
  a_blank_cause: assert property ($rose(supervision_blank)
    |-> $past(take)) else $error("blank without write");
  a_blank_length: assert property ($fell(supervision_blank)
    |-> blank_len == BLANK_CYCLES) else $error("blank length wrong");
  a_cfg_cause: assert property (!$stable(cfg) && $past(rst_n, 2)
    |-> $past(take)) else $error("cfg changed without write");
  a_code_flag: assert property (rst_n && $past(rst_n, 2) &&
    $stable(cfg) |-> code_reserved == (cfg.code >= 6'h35))
    else $error("reserved flag wrong");
  a_voltage_map: assert property ($past(rst_n, 2) && $stable(cfg)
    |-> setpoint_mv == exp_mv) else $error("setpoint mv wrong");
  a_rsvd_zero: assert property (cfg.reserved == 1'b0 &&
    avs_readdata[31:8] == 24'h000000) else $error("reserved bits set");
endmodule

bind buck_boost_setpoint_reg setpoint_monitor #(
  .BLANK_CYCLES(BLANK_CYCLES)) mon (.mclk(mclk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ov_fault_raw(ov_fault_raw), .uv_fault_raw(uv_fault_raw),
  .ov_fault(ov_fault), .uv_fault(uv_fault), .cfg(cfg),
  .supervision_blank(supervision_blank), .setpoint_mv(setpoint_mv),
  .code_reserved(code_reserved));

// File: supervision_blank_timer.sv
// Blanking timer that masks voltage supervision after a setpoint write
`timescale 1ns/1ps
module supervision_blank_timer #(
  parameter int CYCLES = buck_boost_pkg::BLANK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  output logic active
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count;

  // A new write restarts the full interval rather than extending it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (start) begin
      count <= LOAD;
    end else if (count != '0) begin
      count <= count - CW'(1);
    end
  end

  assign active = (count != '0);

endmodule

// File: testbench.sv
// Self-checking bench for the converter setpoint register
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, strap;
  logic ov_raw, uv_raw, ov_fault, uv_fault, blank, code_reserved;
  logic [7:0] avs_address, d;
  logic [3:0] be;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] setpoint_mv;
  logic [5:0] codes [6] = '{6'h00, 6'h0F, 6'h10, 6'h34, 6'h35, 6'h3F};
  buck_boost_pkg::cfg_t cfg;
  int fail_count, checks_done, n;

  buck_boost_setpoint_reg #(.BLANK_CYCLES(20), .STRAP_VALUE(8'h8A)) uut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .strap_default_select(strap), .ov_fault_raw(ov_raw),
    .uv_fault_raw(uv_raw), .ov_fault(ov_fault), .uv_fault(uv_fault),
    .supervision_blank(blank), .cfg(cfg), .setpoint_mv(setpoint_mv),
    .code_reserved(code_reserved));

  always #12.5 mclk = ~mclk;

  // --------------------
  // Checking and bus
  // --------------------
  task results;
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge
  task bus(input logic rd, input logic [7:0] a, input logic [7:0] wd);
    logic ok;
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    avs_read <= rd;
    avs_write <= !rd;
    ok = 0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge mclk);
      ok = (avs_waitrequest === 1'b0);
      q = avs_readdata;
    end
    if (!ok) begin
      fail_count++;
      results();
    end
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
  endtask

  function automatic logic [11:0] mv(input logic [5:0] c);
    if (c < 6'h10) return 12'h497 + 12'h019 * c;
    if (c < 6'h35) return 12'h640 + 12'h032 * (c - 6'h10);
    return 12'h000;
  endfunction

  initial begin
    mclk = 0; rst_n = 0; avs_address = 0; avs_read = 0; avs_write = 0;
    avs_writedata = 0; be = 4'hF; strap = 0; ov_raw = 0; uv_raw = 0;
    fail_count = 0; checks_done = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    ov_raw <= 1;
    uv_raw <= 1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(cfg, 8'h94);
    chk(setpoint_mv, 12'h708);
    @(posedge mclk);
    bus(1, 8'h64, 8'h00);
    chk(q, 32'h94);
    // Locked write, unlock spent elsewhere, wrong key, lane 0 off
    bus(0, 8'h64, 8'h21);
    bus(1, 8'hC4, 8'h00);
    chk(q[1], 1'b1);
    bus(0, 8'hC0, 8'h7D);
    bus(0, 8'h10, 8'h55);
    bus(0, 8'h64, 8'h21);
    bus(1, 8'h10, 8'h00);
    chk(q, 32'h0);
    bus(0, 8'hC0, 8'h7C);
    bus(0, 8'h64, 8'h21);
    bus(0, 8'hC0, 8'h7D);
    be <= 4'hE;
    bus(0, 8'h64, 8'h21);
    be <= 4'hF;
    bus(1, 8'h64, 8'h00);
    chk(q, 32'h94);
    // Clearing the refused flag also spends the pending unlock
    bus(0, 8'hC4, 8'h02);
    bus(1, 8'hC4, 8'h00);
    chk(q, 32'h00);
    // Codes at every range edge, skip bit toggled, bit 6 written high
    // raw over/under-voltage faults held high
    for (int i = 0; i < 6; i++) begin
      d = {i[0], 1'b1, codes[i]};
      bus(0, 8'hC0, 8'h7D);
      bus(0, 8'h64, d);
      @(negedge mclk);
      chk(cfg, d & 8'hBF);
      chk(setpoint_mv, mv(codes[i]));
      chk(code_reserved, codes[i] >= 6'h35);
      chk({blank, ov_fault, uv_fault}, 3'b100);
      n = 0;
      while (blank !== 1'b0 && n < 40) begin
        @(negedge mclk);
        n++;
      end
      if (n >= 40) begin
        fail_count++;
        results();
      end
      chk(n, 19);
      chk({ov_fault, uv_fault}, 2'b11);
      @(posedge mclk);
      bus(1, 8'h64, 8'h00);
      chk(q, {24'h0, d & 8'hBF});
    end
    // Second reset with the strap high
    rst_n <= 0;
    strap <= 1;
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(cfg, 8'h8A);
    chk(setpoint_mv, 12'h591);
    @(posedge mclk);
    bus(1, 8'hC4, 8'h00);
    chk(q, 32'h08);
    results();
  end
endmodule

// File: write_unlock_gate.sv
// One-shot unlock that must precede each protected register write
`timescale 1ns/1ps
module write_unlock_gate #(
  parameter logic [7:0] KEY = buck_boost_pkg::UNLOCK_KEY
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic key_write,
  input wire logic [7:0] key_data,
  input wire logic other_write,
  output logic unlocked
);

  logic next_unlocked;

  assign next_unlocked = key_write ? (key_data == KEY) :
                         other_write ? 1'b0 : unlocked;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else begin
      unlocked <= next_unlocked;
    end
  end

endmodule
